/* File: ssf_sensor.sv */
// sensor end: frame counting, error flags and the small register map
// assumes link pins are asynchronous to I_SYS_CLK and clock idles high
//
// Chosen here: the strobed register port.
module ssf_sensor
  import ssf_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic [15:0] I_ANGLE,
  output logic O_FRAME_ERR,
  output logic O_CRC_ERR,
  ssf_spi_if.dev spi
);

  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  ssf_dev_st_t st_q;
  logic [4:0] cnt_q;
  logic [20:0] rx_q;
  logic [20:0] tx_q;
  logic miso_q;
  logic oe_n_q;
  logic [3:0] guard_q;
  logic pend_q;
  logic [15:0] cmd_q;
  logic long_q;
  logic m16_q;
  logic pow_q;
  logic fe_q;
  logic crc_q;
  logic crc_en_q;

  // three pins through two flops each before any logic looks at them
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      s3_q <= 3'h7;
    end else begin
      s1_q <= {spi.sclk, spi.cs_n, spi.mosi};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  wire sclk_rise = s2_q[2] & ~s3_q[2];
  wire sclk_fall = ~s2_q[2] & s3_q[2];
  wire cs_low = ~s2_q[1];
  wire cs_fall = s3_q[1] & ~s2_q[1];
  wire cs_rise = ~s3_q[1] & s2_q[1];
  wire mosi_s = s2_q[0];

  // frame decode at deselect
  wire len16 = (cnt_q == `SSF_LEN16);
  wire len20 = (cnt_q == `SSF_LEN20);
  wire len21 = (cnt_q == `SSF_LEN21);
  wire [15:0] frm = len21 ? rx_q[20:5] :
                    len20 ? rx_q[19:4] : rx_q[15:0];
  wire [3:0] crc_rx = len21 ? rx_q[4:1] : rx_q[3:0];
  wire bad_len = ~(len16 | len20 | len21);
  wire bad_sync = frm[15];
  wire bad_tail = len21 & rx_q[0];
  wire frame_bad = bad_len | bad_sync | bad_tail;
  wire crc_bad = (len20 | len21) & crc_en_q & ~frame_bad &
                 (ssf_crc4(frm) != crc_rx);
  wire frame_end = (st_q == SSF_D_XFER) & cs_rise;
  wire frame_ok = frame_end & ~frame_bad & ~crc_bad;

  // clock edges seen while deselected
  wire stray = sclk_fall & ~cs_low;
  wire stray_pow = stray & pow_q;
  wire stray_cnt = stray & ~pow_q & ~long_q;
  wire in_guard = (st_q == SSF_D_GUARD);
  wire drop = in_guard & stray_cnt;

  // pending command acts when the guard after deselect runs out, or at once on a new select within it
  wire commit = in_guard & pend_q & ~drop &
                ((guard_q == 4'h0) | cs_fall);
  wire [5:0] c_addr = cmd_q[13:8];
  wire c_wr = cmd_q[14];
  wire [7:0] c_dat = cmd_q[7:0];
  wire wr_err = commit & c_wr & (c_addr == `SSF_A_ERR);
  wire wr_cfg = commit & c_wr & (c_addr == `SSF_A_CFG);

  wire [15:0] err_word = {6'h00, fe_q, crc_q, 8'h00};
  wire [15:0] cfg_word = {15'h0000, crc_en_q};
  wire [15:0] rd_word;
  wire [4:0] c_word = c_addr[5:1];
  assign rd_word = (c_word == 5'(`SSF_A_NULL >> 1)) ? 16'h0000 :
                   (c_word == 5'(`SSF_A_ERR >> 1)) ? err_word :
                   (c_word == 5'(`SSF_A_CFG >> 1)) ? cfg_word :
                   (c_word == 5'(`SSF_A_ANGLE >> 1)) ? I_ANGLE :
                   16'h0000;
  wire [3:0] rd_crc = ssf_crc4(rd_word);

  // flags: a set in the same cycle as a clear wins
  wire fe_set = (frame_end & frame_bad) | stray_pow | stray_cnt;
  wire crc_set = (frame_end & crc_bad) | (stray_pow & crc_en_q);
  wire fe_clr = wr_err & c_dat[`SSF_ERR_FE - 8];
  wire crc_clr = wr_err & c_dat[`SSF_ERR_CRC - 8];

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fe_q <= 1'b0;
      crc_q <= 1'b0;
      crc_en_q <= `SSF_CFG_RST;
      pow_q <= 1'b1;
    end else begin
      fe_q <= (fe_q & ~fe_clr) | fe_set;
      crc_q <= (crc_q & ~crc_clr) | crc_set;
      if (wr_cfg) begin
        crc_en_q <= c_dat[`SSF_CFG_CRC_EN];
      end
      // the power-up artefact happens once and leaves no other trace
      if (stray | frame_end) begin
        pow_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q <= SSF_D_IDLE;
      cnt_q <= 5'h00;
      rx_q <= 21'h000000;
      guard_q <= 4'h0;
    end else begin
      case (st_q)
        SSF_D_IDLE: begin
          if (cs_fall) begin
            st_q <= SSF_D_XFER;
            cnt_q <= 5'h00;
          end
        end
        SSF_D_XFER: begin
          if (cs_rise) begin
            st_q <= SSF_D_GUARD;
            guard_q <= 4'(`SSF_GUARD_CYC - 1);
          end else if (sclk_rise) begin
            rx_q <= {rx_q[19:0], mosi_s};
            if (cnt_q != 5'h1f) begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
        end
        SSF_D_GUARD: begin
          if (cs_fall) begin
            st_q <= SSF_D_XFER;
            cnt_q <= 5'h00;
          end else if (guard_q == 4'h0) begin
            st_q <= SSF_D_IDLE;
          end else begin
            guard_q <= guard_q - 4'h1;
          end
        end
        default: begin
          st_q <= SSF_D_IDLE;
        end
      endcase
    end
  end

  // command capture, mode memory and reply load
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pend_q <= 1'b0;
      cmd_q <= 16'h0000;
      long_q <= 1'b0;
      m16_q <= 1'b0;
    end else begin
      if (frame_ok) begin
        pend_q <= 1'b1;
        cmd_q <= frm;
        long_q <= len21;
        m16_q <= len16;
      end else if (drop | commit) begin
        pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tx_q <= 21'h000000;
      miso_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      if (commit) begin
        tx_q <= {rd_word, rd_crc, rd_crc[3]};
      end else if (sclk_fall & (cs_low | (stray_cnt & m16_q))) begin
        // short frames keep shifting when deselected: next reply skews
        tx_q <= {tx_q[19:0], 1'b0};
      end
      if (sclk_fall & cs_low) begin
        miso_q <= tx_q[20];
      end
      if (cs_fall) begin
        oe_n_q <= 1'b0;
      end else if (cs_rise) begin
        oe_n_q <= 1'b1;
      end
    end
  end

  assign spi.miso_o = miso_q;
  assign spi.miso_oe_n = oe_n_q;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_FRAME_ERR <= 1'b0;
      O_CRC_ERR <= 1'b0;
    end else begin
      O_FRAME_ERR <= fe_q;
      O_CRC_ERR <= crc_q;
    end
  end

endmodule

/* File: ssf_regs.svh */
// constants of the shared-bus sensor framing block: offsets, fields, timing
// assumes inclusion by both ends and by the package
//
// What this block does
// - host holds own clock high while deselected
// - 21-bit mode stops counting clocks while deselected
// - host sends exactly 21 clocks per long frame
// - frame: sync 0, rw, address, data, crc, trailing 0
// - 21st zero shifts 20-bit frame up one
// - reply: 16 data, 4 crc, crc msb repeated
// - host ignores repeated crc bit in check
// - idle sensor flags first bus transaction after reset
// - power-up false flag leaves later accesses intact
// - power-up false flag sets crc error only with crc check on
// - host software clears all flags after reset
// - address zero reads as all zeros
// - 16-bit: stray edges flag, corrupt next reply
// - host discards first reply, inserts null reads
// - 16-bit: flag raised at every chip switch
// - 20-bit: reply intact past guard, flag possible
// - host prefers 21-bit frames on shared bus
// - frame error: wrong clock count, sync 1 or 21st bit 1
// - 16-bit: one low edge deselected flags
// - 16/20-bit: edge within guard after deselect drops command
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH

`define SSF_CLK_NS 5
`define SSF_GUARD_NS 70
`define SSF_GUARD_CYC (`SSF_GUARD_NS / `SSF_CLK_NS)

`define SSF_LEN16 5'h10
`define SSF_LEN20 5'h14
`define SSF_LEN21 5'h15

`define SSF_CRC_POLY 4'h3
`define SSF_CRC_SEED 4'hf

`define SSF_A_NULL 6'h00
`define SSF_A_CFG 6'h1f
`define SSF_A_ANGLE 6'h20
`define SSF_A_ERR 6'h24
`define SSF_ERR_FE 9
`define SSF_ERR_CRC 8
`define SSF_CFG_CRC_EN 0
`define SSF_CFG_RST 1'b0

`define SSF_HALF_CYC 10
`define SSF_H_CMD 2'h0
`define SSF_H_CFG 2'h1
`define SSF_H_STAT 2'h2
`define SSF_H_RXD 2'h3
`define SSF_H_CFG_RST 2'h2

`endif

/* File: ssf_pkg.sv */
// types and the crc helper shared by both ends
// assumes ssf_regs.svh is on the include path
`include "ssf_regs.svh"

package ssf_pkg;

  typedef enum logic [1:0] {
    SSF_L16 = 2'h0,
    SSF_L20 = 2'h1,
    SSF_L21 = 2'h2
  } ssf_len_t;

  typedef enum logic [1:0] {
    SSF_D_IDLE = 2'h0,
    SSF_D_XFER = 2'h1,
    SSF_D_GUARD = 2'h3
  } ssf_dev_st_t;

  typedef enum logic [2:0] {
    SSF_H_IDLE = 3'h0,
    SSF_H_SETUP = 3'h1,
    SSF_H_LOW = 3'h3,
    SSF_H_HIGH = 3'h2,
    SSF_H_GAP = 3'h6
  } ssf_host_st_t;

  function automatic logic [3:0] ssf_crc4(input logic [15:0] d);
    logic [3:0] c;
    logic fb;
    c = `SSF_CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      fb = c[3] ^ d[i];
      c = {c[2:0], 1'b0} ^ (fb ? `SSF_CRC_POLY : 4'h0);
    end
    return c;
  endfunction

endpackage

/* File: ssf_spi_if.sv */
// serial link between the host controller and one sensor
// assumes the bench joins several of these when the lines are shared
interface ssf_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  logic miso;

  // released line reads high, as with a weak pull-up
  assign miso = miso_oe_n ? 1'b1 : miso_o;

  modport dev (
    input sclk,
    input cs_n,
    input mosi,
    output miso_o,
    output miso_oe_n
  );

  modport host (
    output sclk,
    output cs_n,
    output mosi,
    input miso
  );
endinterface

/* File: ssf_ctrl.sv */
// host end: builds frames on command, derives the serial clock by division
// assumes one sensor per interface; software orders frames via registers
module ssf_ctrl
  import ssf_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic [1:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [15:0] O_RDATA,
  ssf_spi_if.host spi
);

  ssf_host_st_t st_q;
  logic [4:0] tmr_q;
  logic [4:0] bits_q;
  logic [20:0] sh_q;
  logic [20:0] rx_q;
  logic sclk_q;
  logic cs_n_q;
  logic mosi_q;
  logic m1_q;
  logic m2_q;
  ssf_len_t len_q;
  ssf_len_t cur_q;
  logic [15:0] rxd_q;
  logic crc_bad_q;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      m1_q <= 1'b1;
      m2_q <= 1'b1;
    end else begin
      m1_q <= spi.miso;
      m2_q <= m1_q;
    end
  end

  wire busy = (st_q != SSF_H_IDLE);
  wire start = I_WR & (I_ADDR == `SSF_H_CMD) & ~busy;
  wire [15:0] frm = {1'b0, I_WDATA[14:0]};
  wire [3:0] fcrc = ssf_crc4(frm);
  wire [4:0] nbits = (len_q == SSF_L16) ? `SSF_LEN16 :
                     (len_q == SSF_L20) ? `SSF_LEN20 : `SSF_LEN21;
  wire tmr_end = (tmr_q == 5'h00);
  wire [4:0] half = 5'(`SSF_HALF_CYC - 1);

  // repeated crc bit in rx_q[0] is left out of the check
  wire [15:0] r_dat = (cur_q == SSF_L21) ? rx_q[20:5] :
                      (cur_q == SSF_L20) ? rx_q[19:4] : rx_q[15:0];
  wire [3:0] r_crc = (cur_q == SSF_L21) ? rx_q[4:1] : rx_q[3:0];
  wire r_bad = (cur_q != SSF_L16) & (ssf_crc4(r_dat) != r_crc);

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q <= SSF_H_IDLE;
      tmr_q <= 5'h00;
      bits_q <= 5'h00;
      sh_q <= 21'h000000;
      rx_q <= 21'h000000;
      sclk_q <= 1'b1;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      cur_q <= SSF_L21;
    end else begin
      case (st_q)
        SSF_H_IDLE: begin
          if (start) begin
            cs_n_q <= 1'b0;
            sh_q <= {frm, fcrc, 1'b0};
            bits_q <= nbits;
            cur_q <= len_q;
            tmr_q <= half;
            st_q <= SSF_H_SETUP;
          end
        end
        SSF_H_SETUP, SSF_H_HIGH: begin
          if (!tmr_end) begin
            tmr_q <= tmr_q - 5'h01;
          end else if (bits_q == 5'h00) begin
            cs_n_q <= 1'b1;
            tmr_q <= 5'(2 * `SSF_HALF_CYC - 1);
            st_q <= SSF_H_GAP;
          end else begin
            sclk_q <= 1'b0;
            mosi_q <= sh_q[20];
            sh_q <= {sh_q[19:0], 1'b0};
            tmr_q <= half;
            st_q <= SSF_H_LOW;
          end
        end
        SSF_H_LOW: begin
          if (!tmr_end) begin
            tmr_q <= tmr_q - 5'h01;
          end else begin
            sclk_q <= 1'b1;
            rx_q <= {rx_q[19:0], m2_q};
            bits_q <= bits_q - 5'h01;
            tmr_q <= half;
            st_q <= SSF_H_HIGH;
          end
        end
        SSF_H_GAP: begin
          // clock stays high all through the deselected gap
          sclk_q <= 1'b1;
          if (!tmr_end) begin
            tmr_q <= tmr_q - 5'h01;
          end else begin
            st_q <= SSF_H_IDLE;
          end
        end
        default: begin
          st_q <= SSF_H_IDLE;
        end
      endcase
    end
  end

  // reply is taken on the edge that raises chip select
  wire gap_in = (st_q == SSF_H_HIGH) & tmr_end & (bits_q == 5'h00);
  wire cfg_wr = I_WR & (I_ADDR == `SSF_H_CFG);

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      len_q <= ssf_len_t'(`SSF_H_CFG_RST);
      rxd_q <= 16'h0000;
      crc_bad_q <= 1'b0;
    end else begin
      if (cfg_wr && I_WDATA[1:0] != 2'h3) begin
        len_q <= ssf_len_t'(I_WDATA[1:0]);
      end
      if (gap_in) begin
        rxd_q <= r_dat;
        crc_bad_q <= r_bad;
      end
    end
  end

  wire [15:0] rd_val = (I_ADDR == `SSF_H_CFG) ? {14'h0000, len_q} :
                       (I_ADDR == `SSF_H_STAT) ? {14'h0000, crc_bad_q, busy} :
                       (I_ADDR == `SSF_H_RXD) ? rxd_q : 16'h0000;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RDATA <= 16'h0000;
    end else if (I_RD) begin
      O_RDATA <= rd_val;
    end
  end

  assign spi.sclk = sclk_q;
  assign spi.cs_n = cs_n_q;
  assign spi.mosi = mosi_q;

endmodule

/* File: ssf_asserts.sv */
// wire checks on the link that joins the host to the sensors
// assumes the plain signals of that link and the system clock domain
module ssf_asserts (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n,
  input wire logic miso
);
  logic sclk_q;
  logic last_q;
  logic crc_q;
  logic [4:0] nrise_q;
  logic [4:0] nfall_q;
  wire rise_w = sclk & ~sclk_q;
  wire fall_w = ~sclk & sclk_q;

  // counters clear while deselected so they hold one frame at the rise
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sclk_q <= 1'b1;
      last_q <= 1'b0;
      crc_q <= 1'b0;
      nrise_q <= 5'h00;
      nfall_q <= 5'h00;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        nrise_q <= 5'h00;
        nfall_q <= 5'h00;
      end else begin
        if (rise_w) begin
          nrise_q <= nrise_q + 5'h01;
          last_q <= mosi;
        end
        if (rise_w && nrise_q == 5'h10) begin
          crc_q <= miso;
        end
        if (fall_w) begin
          nfall_q <= nfall_q + 5'h01;
        end
      end
    end
  end

  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  property p_idle_clk; cs_n |-> sclk; endproperty
  a_idle_clk: assert property (p_idle_clk)
    else $error("clock moved while deselected");
  property p_len;
    $rose(cs_n) |-> nfall_q == nrise_q && (nrise_q == 5'h10 ||
      nrise_q == 5'h14 || nrise_q == 5'h15);
  endproperty
  a_len: assert property (p_len)
    else $error("frame clock count wrong");
  property p_sync; rise_w && !cs_n && nrise_q == 5'h00 |-> !mosi; endproperty
  a_sync: assert property (p_sync)
    else $error("first frame bit not zero");
  property p_tail; $rose(cs_n) && nrise_q == 5'h15 |-> !last_q; endproperty
  a_tail: assert property (p_tail)
    else $error("long frame tail bit not zero");
  property p_crc_rep;
    rise_w && !cs_n && nrise_q == 5'h14 |-> miso == crc_q;
  endproperty
  a_crc_rep: assert property (p_crc_rep)
    else $error("last reply bit not the crc top bit");
  property p_mosi_hold;
    !cs_n && sclk && sclk_q |-> $stable(mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("host data moved while clock high");
  property p_release; cs_n [*8] |-> miso_oe_n; endproperty
  a_release: assert property (p_release)
    else $error("reply line held while deselected");
  property p_drive; !cs_n && nrise_q != 5'h00 |-> !miso_oe_n; endproperty
  a_drive: assert property (p_drive)
    else $error("reply line not driven in frame");
  property p_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
  a_gap: assert property (p_gap)
    else $error("deselect gap too short");
endmodule

/* File: testbench.sv */
// one host and two sensors sharing clock, data and reply lines
// assumes the design files and ssf_asserts.sv are compiled before it
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] ang_a = 16'h1234;
  localparam logic [15:0] ang_b = 16'h5678;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] rdat;
  logic fe_a, ce_a, fe_b, ce_b;
  int fails = 0;
  int checks = 0;
  // rows: sensor, length code, command, reply expected in this frame
  logic [34:0] rows [7] = '{
    {1'b0, 2'h2, 16'h2000, 16'h0000}, {1'b0, 2'h2, 16'h0000, ang_a},
    {1'b1, 2'h2, 16'h2000, 16'h0000}, {1'b1, 2'h2, 16'h0000, ang_b},
    {1'b0, 2'h1, 16'h2000, 16'h0000}, {1'b1, 2'h2, 16'h0000, 16'h0000},
    {1'b0, 2'h1, 16'h0000, ang_a}};
  ssf_spi_if h ();
  ssf_spi_if a ();
  ssf_spi_if b ();
  // the deselected sensor still sees every clock edge of the other
  assign a.sclk = h.sclk;
  assign b.sclk = h.sclk;
  assign a.mosi = h.mosi;
  assign b.mosi = h.mosi;
  assign a.cs_n = h.cs_n | sel;
  assign b.cs_n = h.cs_n | ~sel;
  assign h.miso_oe_n = a.miso_oe_n & b.miso_oe_n;
  assign h.miso_o = a.miso_oe_n ? b.miso_o : a.miso_o;

  ssf_ctrl i_ssf_ctrl (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .spi(h));
  ssf_sensor i_ssf_sensor (.I_SYS_CLK(clk), .I_RST_N(rst_n),
    .I_ANGLE(ang_a), .O_FRAME_ERR(fe_a), .O_CRC_ERR(ce_a), .spi(a));
  ssf_sensor i_ssf_sensor_b (.I_SYS_CLK(clk), .I_RST_N(rst_n),
    .I_ANGLE(ang_b), .O_FRAME_ERR(fe_b), .O_CRC_ERR(ce_b), .spi(b));
  ssf_asserts i_ssf_asserts (.I_SYS_CLK(clk), .I_RST_N(rst_n),
    .sclk(h.sclk), .cs_n(h.cs_n), .mosi(h.mosi), .miso_o(h.miso_o),
    .miso_oe_n(h.miso_oe_n), .miso(h.miso));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic complete_run;
    if (fails == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [1:0] ra, input logic [15:0] d);
    @(posedge clk);
    addr <= ra;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] ra);
    @(posedge clk);
    addr <= ra;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 rdat = rdata;
  endtask

  // the watchdog catches a host that never drops busy
  task automatic idle;
    int n;
    n = 0;
    rdat = 16'hffff;
    while (rdat[0] !== 1'b0 && n < 400) begin
      rd(2'h2);
      n++;
    end
    chk("busy", 16'h0000, {15'h0, rdat[0]});
  endtask

  task automatic frame(input logic s, input logic [15:0] c);
    @(posedge clk);
    sel <= s;
    wr(2'h0, c);
    idle();
  endtask

  initial begin
    #300us;
    fails++;
    complete_run();
  end

  initial begin
    logic s;
    logic [1:0] l;
    logic [15:0] c;
    logic [15:0] x;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    frame(1'b0, 16'h0000);
    chk("fe_b", 16'h0001, {15'h0, fe_b});
    chk("ce_b", 16'h0000, {15'h0, ce_b});
    chk("fe_a", 16'h0000, {15'h0, fe_a});
    frame(1'b1, 16'h6403);
    frame(1'b1, 16'h0000);
    chk("fe_b", 16'h0000, {15'h0, fe_b});
    foreach (rows[i]) begin
      {s, l, c, x} = rows[i];
      wr(2'h1, {14'h0, l});
      frame(s, c);
      rd(2'h3);
      chk("rxd", x, rdat);
      rd(2'h2);
      chk("stat", 16'h0000, rdat);
      chk("fe_b", 16'h0000, {15'h0, fe_b});
    end
    wr(2'h1, 16'h0003);
    rd(2'h1);
    chk("cfg", 16'h0001, rdat);
    wr(2'h1, 16'h0000);
    // clear the flag left by earlier strays so the next one is seen
    frame(1'b0, 16'h6403);
    frame(1'b0, 16'h2000);
    chk("fe_a", 16'h0000, {15'h0, fe_a});
    frame(1'b1, 16'h0000);
    chk("fe_a", 16'h0001, {15'h0, fe_a});
    wr(2'h1, 16'h0002);
    // the second order lands while busy and must be dropped
    wr(2'h0, 16'h2000);
    wr(2'h0, 16'h0000);
    idle();
    // strays of both frames shifted the short reply out entirely
    frame(1'b0, 16'h2000);
    rd(2'h3);
    chk("rxd", 16'h0000, rdat);
    frame(1'b0, 16'h0000);
    rd(2'h3);
    chk("rxd", ang_a, rdat);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("flags", 16'h0000, {14'h0, fe_a, fe_b});
    rst_n <= 1'b1;
    rd(2'h1);
    chk("cfg", 16'h0002, rdat);
    frame(1'b0, 16'h0000);
    chk("fe_b", 16'h0001, {15'h0, fe_b});
    // mosi crc check on: correct frames still pass and read back
    frame(1'b0, 16'h5f01);
    frame(1'b0, 16'h1e00);
    frame(1'b0, 16'h0000);
    rd(2'h3);
    chk("cfg_a", 16'h0001, rdat);
    chk("ce_a", 16'h0000, {15'h0, ce_a});
    complete_run();
  end
endmodule
